// ---- verilog/sfc_port.sv ----
// serial command port with buffers, array and write fifo
//
// How it works
// - output bits change on falling clock edges, input bits taken on rising ones
// - each input bit is taken one rising edge after its launch
// - both clock idle levels at select fall work, modes 0 and 3
// - output bit launched three to four MCLK cycles after the falling edge, late in a 400 ns clock low period
// - output timing holds only while the clock period is longer than the three to four MCLK cycles of output latency
// - three continuous array read opcodes decoded
// - direct single page read decoded, wraps inside the page
// - buffer read, one opcode per buffer
// - low speed buffer read, one opcode per buffer, no dummy byte
// - protection, lockdown and security register reads decoded
// - status read and identification read decoded
// - page to buffer transfer, one opcode per buffer
// - page program through a buffer, one opcode per buffer
// - buffer to page program, one opcode per buffer
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// write fifo
// ------------------------------------------------------------
module sfc_fifo #(
	parameter int W     = 19,
	parameter int DEPTH = 16
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wp;
	logic [AW:0]  rp;
	logic         full;
	logic         empty;

	// pointers carry one wrap bit
	assign empty     = (wp == rp);
	assign full      = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rp[AW-1:0]];

	// write side
	always_ff @(posedge clk)
	begin
		if (rst)
			wp <= '0;
		else if (in_valid && !full)
		begin
			mem[wp[AW-1:0]] <= in_data;
			wp <= wp + 1'b1;
		end
	end

	// read side
	always_ff @(posedge clk)
	begin
		if (rst)
			rp <= '0;
		else if (out_ready && !empty)
			rp <= rp + 1'b1;
	end
endmodule

// ------------------------------------------------------------
// command port
// ------------------------------------------------------------
module sfc_port #(
	parameter int         PAGES      = 4096,
	parameter int         PAGE_BYTES = 528,
	parameter logic [7:0] ID_MFR     = 8'h5A, // arbitrary value
	parameter logic [7:0] ID_DEV     = 8'h3C, // arbitrary value
	parameter logic [3:0] DENS_CODE  = 4'h0,
	parameter logic [7:0] SEC_SEED   = 8'hA5
) (
	input  wire logic MCLK,
	input  wire logic RESET,
	input  wire logic CS_N,
	input  wire logic SCK,
	input  wire logic SI,
	input  wire logic RESET_PIN_N,
	output logic      SO,
	output logic      SO_OE_N
);
	import sfc_pkg::*;

	localparam int IDX_W = $clog2(PAGES * PAGE_BYTES);
	localparam int WW    = $bits(sfc_wr_t);

	logic [7:0] arr [PAGES * PAGE_BYTES];
	logic [7:0] bufm [2][PAGE_BYTES];
	logic [3:0] sck_s;
	logic [3:0] cs_s;
	logic [3:0] si_s;
	logic [1:0] rp_s;
	logic       rst;
	logic       cs_high;
	logic       cs_rise;
	logic       sck_rise;
	logic       sck_fall;
	logic       si_bit;
	logic [6:0] sh;
	logic [2:0] bit_cnt;
	logic       byte_done;
	logic [7:0] rx_byte;
	sfc_phase_t phase;
	sfc_cmd_t   cmd;
	sfc_cmd_t   dec;
	logic [1:0] hdr_cnt;
	logic [15:0] addr_sh;
	logic       hdr_done;
	logic [PAGE_W-1:0] pg;
	logic [BYTE_W-1:0] ptr;
	logic       rd_active;
	logic       tx_load;
	logic       wr_push;
	logic [2:0] out_cnt;
	logic [6:0] tx_sh;
	logic [7:0] tx_byte;
	logic       ovr;
	sfc_eng_t   eng;
	sfc_act_t   pend;
	logic       pend_sel;
	logic       eng_sel;
	logic [PAGE_W-1:0] pend_pg;
	logic [PAGE_W-1:0] eng_pg;
	logic [BYTE_W-1:0] ecnt;
	logic       ecnt_last;
	logic       busy;
	logic       f_in_ready;
	logic       f_out_valid;
	logic       f_out_ready;
	logic [WW-1:0] f_out;
	sfc_wr_t    wr_word;

	// opcode table, one entry per command
	function automatic sfc_cmd_t decode(input logic [7:0] op);
		sfc_cmd_t c;
		c = '{RK_NONE, ACT_NONE, 1'b0, DUM_NONE, 1'b0, 1'b0};
		case (op)
			OP_RD_LEGACY: c = '{RK_ARRAY, ACT_NONE, 1'b1, DUM_LONG, 1'b1, 1'b0};
			OP_RD_FAST:   c = '{RK_ARRAY, ACT_NONE, 1'b1, DUM_ONE, 1'b1, 1'b0};
			OP_RD_SLOW:   c = '{RK_ARRAY, ACT_NONE, 1'b1, DUM_NONE, 1'b1, 1'b0};
			OP_PG_RD:     c = '{RK_PAGE, ACT_NONE, 1'b1, DUM_LONG, 1'b1, 1'b0};
			OP_BUF1_RD:   c = '{RK_BUF, ACT_NONE, 1'b1, DUM_ONE, 1'b1, 1'b0};
			OP_BUF2_RD:   c = '{RK_BUF, ACT_NONE, 1'b1, DUM_ONE, 1'b1, 1'b1};
			OP_BUF1_RDS:  c = '{RK_BUF, ACT_NONE, 1'b1, DUM_NONE, 1'b1, 1'b0};
			OP_BUF2_RDS:  c = '{RK_BUF, ACT_NONE, 1'b1, DUM_NONE, 1'b1, 1'b1};
			OP_PROT_RD:   c = '{RK_PROT, ACT_NONE, 1'b0, DUM_REG, 1'b1, 1'b0};
			OP_LOCK_RD:   c = '{RK_LOCK, ACT_NONE, 1'b0, DUM_REG, 1'b1, 1'b0};
			OP_SEC_RD:    c = '{RK_SEC, ACT_NONE, 1'b0, DUM_REG, 1'b1, 1'b0};
			OP_STAT_RD:   c = '{RK_STAT, ACT_NONE, 1'b0, DUM_NONE, 1'b1, 1'b0};
			OP_ID_RD:     c = '{RK_ID, ACT_NONE, 1'b0, DUM_NONE, 1'b1, 1'b0};
			OP_BUF1_WR:   c = '{RK_WRBUF, ACT_NONE, 1'b1, DUM_NONE, 1'b1, 1'b0};
			OP_BUF2_WR:   c = '{RK_WRBUF, ACT_NONE, 1'b1, DUM_NONE, 1'b1, 1'b1};
			OP_XFER1:     c = '{RK_NONE, ACT_LOAD, 1'b1, DUM_NONE, 1'b1, 1'b0};
			OP_XFER2:     c = '{RK_NONE, ACT_LOAD, 1'b1, DUM_NONE, 1'b1, 1'b1};
			OP_PGPROG1:   c = '{RK_WRBUF, ACT_PROG, 1'b1, DUM_NONE, 1'b1, 1'b0};
			OP_PGPROG2:   c = '{RK_WRBUF, ACT_PROG, 1'b1, DUM_NONE, 1'b1, 1'b1};
			OP_BPROG1:    c = '{RK_NONE, ACT_PROG, 1'b1, DUM_NONE, 1'b1, 1'b0};
			OP_BPROG2:    c = '{RK_NONE, ACT_PROG, 1'b1, DUM_NONE, 1'b1, 1'b1};
			OP_REWR1:     c = '{RK_NONE, ACT_BOTH, 1'b1, DUM_NONE, 1'b1, 1'b0};
			OP_REWR2:     c = '{RK_NONE, ACT_BOTH, 1'b1, DUM_NONE, 1'b1, 1'b1};
			default:      c.known = 1'b0;
		endcase
		return c;
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers and edge finding
	// ------------------------------------------------------------
	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			sck_s <= 4'h0;
			cs_s  <= 4'hF;
			si_s  <= 4'h0;
			rp_s  <= 2'h0;
		end
		else
		begin
			sck_s <= {sck_s[2:0], SCK};
			cs_s  <= {cs_s[2:0], CS_N};
			si_s  <= {si_s[2:0], SI};
			rp_s  <= {rp_s[0], RESET_PIN_N};
		end
	end

	assign rst      = RESET || !rp_s[1];
	assign cs_high  = cs_s[2];
	assign cs_rise  = cs_s[2] && !cs_s[3];
	assign sck_rise = sck_s[2] && !sck_s[3] && !cs_high;
	assign sck_fall = !sck_s[2] && sck_s[3] && !cs_high;
	// sample from the last edge that still saw the clock low: the host moves SI on the rise
	assign si_bit    = si_s[3];
	assign rx_byte   = {sh, si_bit};
	assign byte_done = sck_rise && (bit_cnt == 3'h7);
	assign dec       = decode(rx_byte);

	// ------------------------------------------------------------
	// input shifter
	// ------------------------------------------------------------
	always_ff @(posedge MCLK)
	begin
		if (rst || cs_high)
		begin
			sh      <= 7'h00;
			bit_cnt <= 3'h0;
		end
		else if (sck_rise)
		begin
			sh      <= rx_byte[6:0];
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// frame phases, command and pointers
	// ------------------------------------------------------------
	assign rd_active = !cs_high && (phase == PH_DATA) && (cmd.kind != RK_NONE)
		&& (cmd.kind != RK_WRBUF);
	assign tx_load = sck_fall && rd_active && (out_cnt == 3'h0);
	assign wr_push = byte_done && (phase == PH_DATA) && (cmd.kind == RK_WRBUF);

	always_ff @(posedge MCLK)
	begin
		if (rst || cs_high)
		begin
			phase    <= PH_OPCODE;
			hdr_cnt  <= 2'h0;
			hdr_done <= 1'b0;
		end
		// data bytes fall through to the pointer step below
		else if (byte_done && phase != PH_DATA)
		begin
			case (phase)
				PH_OPCODE:
				begin
					cmd     <= dec;
					hdr_cnt <= 2'h0;
					ptr     <= '0;
					if (!dec.known || (busy && dec.kind != RK_STAT))
						phase <= PH_IGNORE;
					else if (dec.has_addr)
						phase <= PH_ADDR;
					else if (dec.dummies != DUM_NONE)
						phase <= PH_DUMMY;
					else
						phase <= PH_DATA;
				end
				PH_ADDR:
				begin
					addr_sh <= {addr_sh[7:0], rx_byte};
					hdr_cnt <= hdr_cnt + 2'h1;
					if (hdr_cnt == ADDR_LAST)
					begin
						// page field sits above the byte field in the first two bytes
						pg      <= addr_sh[PAGE_LSB-8 +: PAGE_W];
						ptr     <= {addr_sh[BYTE_W-9:0], rx_byte};
						hdr_cnt <= 2'h0;
						phase   <= (cmd.dummies != DUM_NONE) ? PH_DUMMY : PH_DATA;
					end
				end
				PH_DUMMY:
				begin
					hdr_cnt <= hdr_cnt + 2'h1;
					if ({1'b0, hdr_cnt} == cmd.dummies - 3'h1)
						phase <= PH_DATA;
				end
				default: ;
			endcase
		end
		else if (tx_load || wr_push)
		begin
			// buffers and single page wrap, array reads run on
			if (ptr == BYTE_W'(PAGE_BYTES - 1))
			begin
				ptr <= '0;
				if (cmd.kind == RK_ARRAY)
					pg <= pg + 1'b1;
			end
			else
				ptr <= ptr + 1'b1;
		end
		if (!rst && !cs_high && phase == PH_DATA)
			hdr_done <= 1'b1;
	end

	// ------------------------------------------------------------
	// output byte selection
	// ------------------------------------------------------------
	always_comb
	begin
		tx_byte = 8'h00;
		case (cmd.kind)
			RK_ARRAY, RK_PAGE: tx_byte = arr[IDX_W'(pg * PAGE_BYTES + ptr)];
			RK_BUF:  tx_byte = bufm[cmd.buf_sel][ptr];
			RK_PROT, RK_LOCK: tx_byte = 8'h00;
			RK_SEC:  tx_byte = SEC_SEED ^ ptr[7:0];
			RK_STAT: tx_byte = {!busy, ovr, DENS_CODE, 2'b00};
			RK_ID:   tx_byte = (ptr == '0) ? ID_MFR : (ptr == 1) ? ID_DEV : 8'h00;
			default: tx_byte = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// output shifter, launched on falling edges
	// ------------------------------------------------------------
	always_ff @(posedge MCLK)
	begin
		if (rst || cs_high)
		begin
			SO      <= 1'b0;
			SO_OE_N <= 1'b1;
			tx_sh   <= 7'h00;
			out_cnt <= 3'h0;
		end
		else
		begin
			SO_OE_N <= !rd_active;
			if (tx_load)
			begin
				SO      <= tx_byte[7];
				tx_sh   <= tx_byte[6:0];
				out_cnt <= 3'h1;
			end
			else if (sck_fall && rd_active)
			begin
				SO      <= tx_sh[6];
				tx_sh   <= {tx_sh[5:0], 1'b0};
				out_cnt <= out_cnt + 3'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// write fifo between serial side and buffers
	// ------------------------------------------------------------
	assign wr_word     = '{cmd.buf_sel, ptr, rx_byte};
	assign f_out_ready = (eng == EN_IDLE);

	sfc_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (MCLK),
		.rst       (rst),
		.in_valid  (wr_push),
		.in_ready  (f_in_ready),
		.in_data   (wr_word),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out)
	);

	// overrun flag, set wins over the clear by a status read
	always_ff @(posedge MCLK)
	begin
		if (rst)
			ovr <= 1'b0;
		else if (wr_push && !f_in_ready)
			ovr <= 1'b1;
		else if (byte_done && phase == PH_OPCODE && rx_byte == OP_STAT_RD)
			ovr <= 1'b0;
	end

	// ------------------------------------------------------------
	// transfer and program engine, runs after select rises
	// ------------------------------------------------------------
	assign busy      = (eng != EN_IDLE) || (pend != ACT_NONE);
	assign ecnt_last = (ecnt == BYTE_W'(PAGE_BYTES - 1));

	always_ff @(posedge MCLK)
	begin
		if (rst)
		begin
			eng  <= EN_IDLE;
			pend <= ACT_NONE;
			ecnt <= '0;
		end
		else
		begin
			if (cs_rise && hdr_done && cmd.act != ACT_NONE && pend == ACT_NONE)
			begin
				pend     <= cmd.act;
				pend_sel <= cmd.buf_sel;
				pend_pg  <= pg;
			end
			case (eng)
				EN_IDLE:
					if (pend != ACT_NONE && !f_out_valid)
					begin
						eng     <= (pend == ACT_PROG) ? EN_PROG : EN_LOAD;
						eng_sel <= pend_sel;
						eng_pg  <= pend_pg;
						ecnt    <= '0;
					end
				EN_LOAD:
				begin
					ecnt <= ecnt_last ? '0 : ecnt + 1'b1;
					if (ecnt_last)
					begin
						eng  <= (pend == ACT_BOTH) ? EN_PROG : EN_IDLE;
						pend <= (pend == ACT_BOTH) ? ACT_PROG : ACT_NONE;
					end
				end
				EN_PROG:
				begin
					ecnt <= ecnt_last ? '0 : ecnt + 1'b1;
					if (ecnt_last)
					begin
						eng  <= EN_IDLE;
						pend <= ACT_NONE;
					end
				end
				default: eng <= EN_IDLE;
			endcase
		end
	end

	// buffer storage, fed by the fifo or by a page load
	always_ff @(posedge MCLK)
	begin
		if (f_out_valid && f_out_ready)
			bufm[f_out[WW-1]][f_out[8 +: BYTE_W]] <= f_out[7:0];
		else if (eng == EN_LOAD)
			bufm[eng_sel][ecnt] <= arr[IDX_W'(eng_pg * PAGE_BYTES + ecnt)];
	end

	// main array, written only by the program step
	always_ff @(posedge MCLK)
	begin
		if (eng == EN_PROG)
			arr[IDX_W'(eng_pg * PAGE_BYTES + ecnt)] <= bufm[eng_sel][ecnt];
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (rst);

	sequence s_frame_end;
		cs_rise && hdr_done && cmd.act == ACT_LOAD && pend == ACT_NONE;
	endsequence
	sequence s_load_run;
		##[1:40] (eng == EN_LOAD) ##1 (eng == EN_LOAD) [*4];
	endsequence

	chk_capture_rise: assert property (
		(!cs_high && $changed(bit_cnt)) |-> $past(sck_rise))
		else $error("bit counter moved without a rising clock");
	chk_launch_fall: assert property (
		(!cs_high && !$past(cs_high) && $changed(SO)) |-> $past(sck_fall))
		else $error("output changed without a falling clock");
	chk_drive_low: assert property (
		(sck_fall && rd_active) |=> !SO_OE_N [*2])
		else $error("output not driven during clock low");
	chk_select_idle: assert property (
		cs_high |=> (phase == PH_OPCODE) && (bit_cnt == 3'h0))
		else $error("frame state kept while select high");
	chk_mode_start: assert property (
		$fell(cs_high) |-> (bit_cnt == 3'h0) && SO_OE_N)
		else $error("frame did not start clean");
	chk_byte_wrap: assert property (
		byte_done |=> (bit_cnt == 3'h0) || cs_high)
		else $error("bit count did not wrap after eight bits");
	chk_array_decode: assert property (
		(byte_done && phase == PH_OPCODE && !busy && rx_byte == OP_RD_LEGACY)
		|=> (phase == PH_ADDR) && (cmd.dummies == DUM_LONG))
		else $error("array read opcode not decoded");
	chk_status_decode: assert property (
		(byte_done && phase == PH_OPCODE && rx_byte == OP_STAT_RD)
		|=> (phase == PH_DATA) || cs_high)
		else $error("status read did not go straight to data");
	chk_load_start: assert property (
		s_frame_end |-> s_load_run)
		else $error("page load did not start after select rose");
	chk_prog_end: assert property (
		$rose(eng == EN_PROG) |-> ##[1:1000] (eng != EN_PROG))
		else $error("program step did not finish");
endmodule

`default_nettype wire

// ---- include/sfc_pkg.sv ----
// shared constants and types of the serial flash command port
package sfc_pkg;

	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_RD_LEGACY = 8'hE8;
	localparam logic [7:0] OP_RD_FAST   = 8'h0B;
	localparam logic [7:0] OP_RD_SLOW   = 8'h03;
	localparam logic [7:0] OP_PG_RD     = 8'hD2;
	localparam logic [7:0] OP_BUF1_RD   = 8'hD4;
	localparam logic [7:0] OP_BUF2_RD   = 8'hD6;
	localparam logic [7:0] OP_BUF1_RDS  = 8'hD1;
	localparam logic [7:0] OP_BUF2_RDS  = 8'hD3;
	localparam logic [7:0] OP_PROT_RD   = 8'h32;
	localparam logic [7:0] OP_LOCK_RD   = 8'h35;
	localparam logic [7:0] OP_SEC_RD    = 8'h77;
	localparam logic [7:0] OP_STAT_RD   = 8'hD7;
	localparam logic [7:0] OP_ID_RD     = 8'h9F;
	localparam logic [7:0] OP_BUF1_WR   = 8'h84;
	localparam logic [7:0] OP_BUF2_WR   = 8'h87;
	localparam logic [7:0] OP_XFER1     = 8'h53;
	localparam logic [7:0] OP_XFER2     = 8'h55;
	localparam logic [7:0] OP_PGPROG1   = 8'h82;
	localparam logic [7:0] OP_PGPROG2   = 8'h85;
	localparam logic [7:0] OP_BPROG1    = 8'h83;
	localparam logic [7:0] OP_BPROG2    = 8'h86;
	localparam logic [7:0] OP_REWR1     = 8'h58;
	localparam logic [7:0] OP_REWR2     = 8'h59;

	// ------------------------------------------------------------
	// header layout and field positions
	// ------------------------------------------------------------
	localparam logic [2:0] DUM_NONE = 3'h0;
	localparam logic [2:0] DUM_ONE  = 3'h1;
	localparam logic [2:0] DUM_REG  = 3'h3;
	localparam logic [2:0] DUM_LONG = 3'h4;
	localparam logic [1:0] ADDR_LAST = 2'h2;
	localparam int PAGE_LSB   = 10;
	localparam int BYTE_W     = 10;
	localparam int PAGE_W     = 12;
	localparam int PROT_BYTES = 16;
	localparam int ID_BYTES   = 4;
	localparam int STAT_RDY   = 7;
	localparam int STAT_OVR   = 6;
	localparam int STAT_DENS  = 2;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [3:0] {RK_NONE, RK_ARRAY, RK_PAGE, RK_BUF, RK_PROT,
		RK_LOCK, RK_SEC, RK_STAT, RK_ID, RK_WRBUF} sfc_kind_t;
	typedef enum logic [1:0] {ACT_NONE, ACT_LOAD, ACT_PROG, ACT_BOTH} sfc_act_t;
	typedef enum logic [4:0] {PH_OPCODE = 5'b00001, PH_ADDR = 5'b00010,
		PH_DUMMY = 5'b00100, PH_DATA = 5'b01000, PH_IGNORE = 5'b10000} sfc_phase_t;
	typedef enum logic [2:0] {EN_IDLE = 3'b001, EN_LOAD = 3'b010,
		EN_PROG = 3'b100} sfc_eng_t;

	typedef struct packed {
		sfc_kind_t  kind;
		sfc_act_t   act;
		logic       has_addr;
		logic [2:0] dummies;
		logic       known;
		logic       buf_sel;
	} sfc_cmd_t;

	typedef struct packed {
		logic              buf_sel;
		logic [BYTE_W-1:0] addr;
		logic [7:0]        data;
	} sfc_wr_t;

endpackage

// ---- testbench/sfc_host.sv ----
// host controller model that drives select, clock and data of the serial link
`timescale 1ns/1ps
`default_nettype none
module sfc_host (
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	input  wire logic so
);
	logic [7:0] txb [0:15];
	logic [7:0] rxb [0:15];

	// deselected and still from time zero, so reset is released with select high
	initial
	begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	// one frame: bits out on rises, bits in on the fall after their launch
	task automatic run(input logic m3, input int n);
		logic [7:0] r;
		r = 8'h00;
		#37;
		sck  = m3;
		// idle level settles while deselected, so select falls on a still clock
		#400;
		si   = txb[0][7];
		cs_n = 1'b0;
		#400;
		if (m3)
		begin
			sck = 1'b0; // leading fall of mode 3 carries nothing
			#400;
		end
		for (int i = 0; i < 8 * n; i++)
		begin
			sck = 1'b1;
			if (i + 1 < 8 * n)
				si = txb[(i + 1) / 8][7 - (i + 1) % 8];
			#400;
			sck = 1'b0;
			r   = {r[6:0], so};
			if (i % 8 == 7)
				rxb[i / 8] = r;
			#400;
		end
		sck  = m3;
		#400;
		cs_n = 1'b1;
		si   = ~si; // released line does not keep its last value
		#800;
	endtask

	// stray clock and data while deselected
	task automatic noise(input int n);
		for (int i = 0; i < n; i++)
		begin
			#400;
			sck = ~sck;
			si  = ~si;
		end
	endtask
endmodule
`default_nettype wire

// ---- testbench/sfc_port_test.sv ----
// self-checking bench of the serial command port
`timescale 1ns/1ps
`default_nettype none
module sfc_port_test;
	import sfc_pkg::*;

	typedef struct packed {
		logic [7:0] op;
		logic       na;
		logic [1:0] page;
		logic [2:0] nd;
		logic [2:0] nw;
		logic [2:0] nr;
		logic [7:0] seed;
		logic       m3;
		logic       wt;
	} sfc_row_t;

	logic mclk;
	logic reset;
	logic reset_pin_n;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe_n;
	int   err_count = 0;
	int   tests_run = 0;

	// ------------------------------------------------------------
	// case table: opcode, address, dummies, writes, reads, data seed
	// ------------------------------------------------------------
	sfc_row_t rows [0:32] = '{
		'{OP_ID_RD,    0, 0, 0, 0, 2, 8'h61, 0, 0},
		'{OP_STAT_RD,  0, 0, 0, 0, 1, 8'h80, 1, 0},
		'{OP_PROT_RD,  0, 0, 3, 0, 1, 8'h00, 0, 0},
		'{OP_LOCK_RD,  0, 0, 3, 0, 1, 8'h00, 1, 0},
		'{OP_SEC_RD,   0, 0, 3, 0, 4, 8'hA4, 0, 0},
		'{OP_BUF1_WR,  1, 0, 0, 4, 0, 8'h10, 0, 0},
		'{OP_BUF2_WR,  1, 0, 0, 4, 0, 8'h40, 1, 0},
		'{OP_BUF1_RD,  1, 0, 1, 0, 4, 8'h10, 1, 0},
		'{OP_BUF2_RD,  1, 0, 1, 0, 4, 8'h40, 0, 0},
		'{OP_BUF1_RDS, 1, 0, 0, 0, 4, 8'h10, 0, 0},
		'{OP_BUF2_RDS, 1, 0, 0, 0, 4, 8'h40, 1, 0},
		'{OP_BPROG1,   1, 1, 0, 0, 0, 8'h00, 0, 1},
		'{OP_PG_RD,    1, 1, 4, 0, 4, 8'h10, 0, 0},
		'{OP_RD_LEGACY,1, 1, 4, 0, 4, 8'h10, 1, 0},
		'{OP_RD_FAST,  1, 1, 1, 0, 4, 8'h10, 0, 0},
		'{OP_RD_SLOW,  1, 1, 0, 0, 4, 8'h10, 0, 0},
		'{OP_XFER2,    1, 1, 0, 0, 0, 8'h00, 0, 1},
		'{OP_BUF2_RD,  1, 0, 1, 0, 4, 8'h10, 0, 0},
		'{OP_BUF1_WR,  1, 0, 0, 4, 0, 8'h70, 0, 0},
		'{OP_XFER1,    1, 1, 0, 0, 0, 8'h00, 1, 1},
		'{OP_BUF1_RD,  1, 0, 1, 0, 4, 8'h10, 0, 0},
		'{OP_PGPROG1,  1, 2, 0, 4, 0, 8'h90, 0, 1},
		'{OP_RD_SLOW,  1, 2, 0, 0, 4, 8'h90, 0, 0},
		'{OP_BPROG2,   1, 0, 0, 0, 0, 8'h00, 0, 1},
		'{OP_RD_FAST,  1, 0, 1, 0, 4, 8'h10, 1, 0},
		'{OP_PGPROG2,  1, 3, 0, 4, 0, 8'hA0, 1, 1},
		'{OP_PG_RD,    1, 3, 4, 0, 4, 8'hA0, 0, 0},
		'{OP_REWR1,    1, 1, 0, 0, 0, 8'h00, 0, 0},
		'{OP_STAT_RD,  0, 0, 0, 0, 1, 8'h00, 0, 1},
		'{OP_REWR2,    1, 2, 0, 0, 0, 8'h00, 0, 1},
		'{OP_RD_FAST,  1, 1, 1, 0, 4, 8'h10, 0, 0},
		'{OP_RD_LEGACY,1, 2, 4, 0, 4, 8'h90, 1, 0},
		'{OP_STAT_RD,  0, 0, 0, 0, 1, 8'h80, 0, 0}
	};

	// ID values are arbitrary, chosen consecutive to fit the table
	sfc_port #(
		.PAGES      (4),
		.ID_MFR     (8'h61),
		.ID_DEV     (8'h62),
		.SEC_SEED   (8'hA4)
	) uut (
		.MCLK        (mclk),
		.RESET       (reset),
		.CS_N        (cs_n),
		.SCK         (sck),
		.SI          (si),
		.RESET_PIN_N (reset_pin_n),
		.SO          (so),
		.SO_OE_N     (so_oe_n)
	);

	sfc_host host (
		.cs_n (cs_n),
		.sck  (sck),
		.si   (si),
		.so   (so)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one frame built from a row, read bytes compared with the seed pattern
	task automatic frame(input sfc_row_t r);
		int          k;
		int          h;
		logic [23:0] a;
		k = 1;
		a = {12'h000, r.page, 10'h005};
		host.txb[0] = r.op;
		if (r.na)
		begin
			host.txb[1] = a[23:16];
			host.txb[2] = a[15:8];
			host.txb[3] = a[7:0];
			k = 4;
		end
		for (int i = 0; i < r.nd + r.nw + r.nr; i++)
			host.txb[k + i] = (i < r.nd || i >= r.nd + r.nw) ? 8'h00 : r.seed + 8'(i - r.nd);
		h = k + r.nd + r.nw;
		@(posedge mclk);
		#2;
		host.run(r.m3, h + r.nr);
		for (int i = 0; i < r.nr; i++)
			check("read byte", r.seed + 8'(i), host.rxb[h + i]);
	endtask

	// poll the status byte until the ready bit shows, bounded
	task automatic wait_ready();
		logic rdy;
		rdy = 1'b0;
		host.txb[1] = 8'h00;
		for (int n = 0; n < 40 && !rdy; n++)
		begin
			host.txb[0] = OP_STAT_RD;
			host.run(1'b0, 2);
			rdy = (host.rxb[1][7] === 1'b1);
		end
		check("ready bit", 8'h01, {7'h00, rdy});
	endtask

	// ------------------------------------------------------------
	// clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever
			#50 mclk = ~mclk;
	end

	initial
	begin
		#5000000;
		err_count++;
		wrap_up();
	end

	initial
	begin
		reset       = 1'b1;
		reset_pin_n = 1'b1;
		repeat (3) @(posedge mclk);
		#2;
		reset = 1'b0;
		check("data out", 8'h00, {7'h00, so});
		check("output enable", 8'h01, {7'h00, so_oe_n});
		repeat (4) @(posedge mclk);
		foreach (rows[i])
		begin
			frame(rows[i]);
			if (rows[i].wt)
				wait_ready();
		end
		// stray activity while deselected, then a clean status read
		host.noise(24);
		check("output enable", 8'h01, {7'h00, so_oe_n});
		frame(rows[1]);
		// hardware reset pin pulsed with select held high
		@(posedge mclk);
		#2;
		reset_pin_n = 1'b0;
		repeat (4) @(posedge mclk);
		#2;
		reset_pin_n = 1'b1;
		repeat (4) @(posedge mclk);
		check("output enable", 8'h01, {7'h00, so_oe_n});
		frame(rows[0]);
		wrap_up();
	end
endmodule
`default_nettype wire
